// File: logic/ers_ctrl.sv
// Purpose: Shadow scoreboard, shadow pointers and return sequencing.
// Assumes: Pipeline reports stage advances and pointer words each cycle.
// Notes:   Control register access is a select, strobe and data port.
`timescale 1ns/10ps
`default_nettype none
module ers_ctrl
  import ers_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        sb_set_i,      // Scoreboard bit set strobe.
  input  wire logic [4:0]  sb_set_idx_i,  // Register index to mark.
  input  wire logic        sb_clr_i,      // Scoreboard bit clear strobe.
  input  wire logic [4:0]  sb_clr_idx_i,  // Register index to release.
  input  wire logic        exc_i,         // Exception recognised pulse.
  input  wire logic        fetch_adv_i,   // Fetch stage moves to next.
  input  wire logic [31:0] fetch_ptr_i,   // Fetch stage pointer word.
  input  wire logic        next_adv_i,    // Next stage moves to exec.
  input  wire logic [31:0] next_ptr_i,    // Next stage pointer word.
  input  wire logic        taken_nodly_i, // Taken branch without delay slot.
  input  wire logic        ret_i,         // Return instruction issued.
  input  wire logic        sync_done_i,   // All earlier work complete.
  input  wire logic        fetch_ack_i,   // Refetched next word arrived.
  input  wire logic        trap_i,        // Trap instruction issued.
  input  wire logic        irq_pend_i,    // Interrupt pending.
  input  wire logic        cr_wr_i,       // Control register write.
  input  wire logic        cr_st_wr_i,    // Status word write.
  input  wire logic        cr_sst_wr_i,   // Saved status word write.
  input  wire logic [1:0]  cr_sel_i,      // Shadow register selector.
  input  wire logic [31:0] cr_wdata_i,    // Control register write data.
  output var  logic [31:0] cr_rdata_o,    // Selected shadow register.
  output var  logic [31:0] live_sb_o,     // Live scoreboard.
  output var  logic [31:0] status_o,      // Status word.
  output var  logic [31:0] saved_status_o,// Saved status word.
  output var  logic        trap_stall_o,  // Trap held by scoreboard.
  output var  logic        ret_busy_o,    // Return sequence in progress.
  output var  logic        refetch_o,     // Prefetch request pulse.
  output var  logic [31:0] refetch_addr_o,// Prefetch word address.
  output var  logic        refetch_mode_o,// Address space for prefetch.
  output var  logic        ret_nop_o,     // Resumed instruction is no-op.
  output var  logic        iaccess_exc_o, // Instruction access exception.
  output var  logic        irq_take_o,    // Interrupt recognised now.
  output var  logic [31:0] exec_ptr_o     // Live exec stage pointer word.
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ers_state_t  st;         // Return sequencer state.
    logic [31:0] sb;         // Live scoreboard.
    logic [31:0] ssb;        // Shadow scoreboard.
    logic [31:0] stw;        // Status word.
    logic [31:0] sstw;       // Saved status word.
    logic [31:0] xptr;       // Live exec stage pointer.
    logic [31:0] rdata;      // Read data register.
    logic        stall;      // Trap stall.
    logic        busy;       // Return busy.
    logic        refetch;    // Prefetch pulse.
    logic [31:0] raddr;      // Prefetch address.
    logic        rmode;      // Prefetch address space.
    logic        nop;        // No-op marker.
    logic        iexc;       // Instruction access exception.
    logic        irq;        // Interrupt take.
  } ers_ctrl_t;
  ers_ctrl_t cur;       // Registered state.
  ers_ctrl_t next_cur;  // Next state.

  logic        shadow_on;  // Shadowing enabled.
  logic [31:0] snp;        // Shadow next pointer.
  logic [31:0] sfp;        // Shadow fetch pointer.
  logic [31:0] sxp;        // Shadow exec pointer.
  logic [31:0] snp_live;   // Value the next shadow follows.
  logic [31:0] sxp_live;   // Value the exec shadow follows.
  logic        snp_track;  // Next shadow update enable.
  logic        sxp_track;  // Exec shadow update enable.
  logic [31:0] sb_upd;     // Live scoreboard after set and clear.

  // Decode a one-hot mask of a register index, zero register excluded.
  function automatic logic [31:0] idx_mask(input logic [4:0] idx);
    logic [31:0] m;
    m = 32'h0000_0001 << idx;
    m[0] = 1'b0;
    return m;
  endfunction

  assign shadow_on = ~cur.stw[ERS_ST_FRZ];

  // ---------------------------------------------------------------
  // Shadow pointer tracking
  // ---------------------------------------------------------------
  // Next shadow: valid drops on an invalid fetch or a squashing branch;
  // fault copies the fetch fault as the fetch stage advances.
  always_comb begin
    snp_live = fetch_ptr_i;
    if (taken_nodly_i) begin
      snp_live[ERS_PTR_VALID] = 1'b0;
    end
  end
  assign snp_track = fetch_adv_i & shadow_on;

  // Exec shadow: fault copies the next stage fault as the next stage advances.
  always_comb begin
    sxp_live = next_ptr_i;
    sxp_live[ERS_PTR_FAULT] = next_ptr_i[ERS_PTR_FAULT];
  end
  assign sxp_track = next_adv_i & shadow_on;

  ers_shadow_ptr u_snp (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .track_i   (snp_track),
    .live_i    (snp_live),
    .wr_i      (cr_wr_i && cr_sel_i == ERS_SEL_SNP),
    .wdata_i   (cr_wdata_i),
    .value_o   (snp)
  );

  ers_shadow_ptr u_sfp (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .track_i   (snp_track),
    .live_i    (fetch_ptr_i),
    .wr_i      (cr_wr_i && cr_sel_i == ERS_SEL_SFP),
    .wdata_i   (cr_wdata_i),
    .value_o   (sfp)
  );

  // The exec shadow has no write strobe: it is read-only.
  ers_shadow_ptr u_sxp (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .track_i   (sxp_track),
    .live_i    (sxp_live),
    .wr_i      (1'b0),
    .wdata_i   (ERS_RST_WORD),
    .value_o   (sxp)
  );

  // ---------------------------------------------------------------
  // Scoreboard, status and return sequencing
  // ---------------------------------------------------------------
  always_comb begin
    sb_upd = cur.sb;
    if (sb_clr_i) begin
      sb_upd = sb_upd & ~idx_mask(sb_clr_idx_i);
    end
    if (sb_set_i) begin
      sb_upd = sb_upd | idx_mask(sb_set_idx_i);
    end
  end

  // Main next-state process.
  always_comb begin
    next_cur         = cur;
    next_cur.refetch = 1'b0;
    next_cur.iexc    = 1'b0;
    next_cur.irq     = 1'b0;
    next_cur.sb      = sb_upd;
    // Shadow scoreboard follows the live one while not frozen.
    if (shadow_on) begin
      next_cur.ssb = sb_upd;
    end
    if (next_adv_i) begin
      next_cur.xptr = sxp_live;
    end
    // Exception: shadow keeps the old value, live is emptied.
    if (exc_i) begin
      next_cur.sb   = ERS_RST_WORD;
      next_cur.ssb  = shadow_on ? cur.sb : cur.ssb;
      next_cur.sstw = cur.stw;
      next_cur.stw  = cur.stw | ERS_RST_ST;
    end
    // Software writes to shadow scoreboard and status words.
    if (cr_wr_i && cr_sel_i == ERS_SEL_SSB) begin
      next_cur.ssb = cr_wdata_i;
    end
    if (cr_st_wr_i) begin
      next_cur.stw = cr_wdata_i;
    end
    if (cr_sst_wr_i) begin
      next_cur.sstw = cr_wdata_i;
    end
    next_cur.ssb[0] = 1'b0;
    // Trap waits for an empty scoreboard.
    next_cur.stall = trap_i && (sb_upd != ERS_RST_WORD);
    case (cur.st)
      ERS_IDLE: begin
        if (ret_i) begin
          next_cur.busy = 1'b1;
          next_cur.st   = ERS_SYNC;
        end
      end
      ERS_SYNC: begin
        if (sync_done_i) begin
          next_cur.st = ERS_LOAD;
        end
      end
      ERS_LOAD: begin
        next_cur.sb    = cur.ssb;
        next_cur.stw   = cur.sstw;
        next_cur.rmode = cur.sstw[ERS_ST_MODE];
        next_cur.raddr = {snp[31:2], 2'h0};
        next_cur.nop   = ~snp[ERS_PTR_VALID];
        next_cur.refetch = snp[ERS_PTR_VALID];
        next_cur.st    = ERS_FETCH;
      end
      ERS_FETCH: begin
        if (!snp[ERS_PTR_VALID] || fetch_ack_i) begin
          next_cur.iexc = snp[ERS_PTR_VALID] & snp[ERS_PTR_FAULT];
          next_cur.raddr = {sfp[31:2], 2'h0};
          next_cur.refetch = sfp[ERS_PTR_VALID];
          next_cur.st = ERS_DONE;
        end
      end
      ERS_DONE: begin
        next_cur.busy = 1'b0;
        next_cur.irq  = irq_pend_i & ~cur.stw[ERS_ST_IND];
        next_cur.st   = ERS_IDLE;
      end
      default: begin
        next_cur.st = ERS_IDLE;
      end
    endcase
    case (cr_sel_i)
      ERS_SEL_SSB: next_cur.rdata = cur.ssb;
      ERS_SEL_SNP: next_cur.rdata = snp;
      ERS_SEL_SXP: next_cur.rdata = sxp;
      default:     next_cur.rdata = sfp;
    endcase
  end

  // Registers all control state.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur      <= '0;
      cur.st   <= ERS_IDLE;
      cur.stw  <= ERS_RST_ST;
    end else begin
      cur <= next_cur;
    end
  end

  assign cr_rdata_o     = cur.rdata;
  assign live_sb_o      = cur.sb;
  assign status_o       = cur.stw;
  assign saved_status_o = cur.sstw;
  assign trap_stall_o   = cur.stall;
  assign ret_busy_o     = cur.busy;
  assign refetch_o      = cur.refetch;
  assign refetch_addr_o = cur.raddr;
  assign refetch_mode_o = cur.rmode;
  assign ret_nop_o      = cur.nop;
  assign iaccess_exc_o  = cur.iexc;
  assign irq_take_o     = cur.irq;
  assign exec_ptr_o     = cur.xptr;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_load;
    cur.st == ERS_LOAD;
  endsequence

  a_ssb_zero_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cur.ssb[0] == 1'b0) else $error("shadow scoreboard bit zero set");
  a_sb_restore: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_load |=> cur.sb == $past(cur.ssb)) else $error("scoreboard not restored");
  a_st_restore: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_load |=> cur.stw == $past(cur.sstw)) else $error("status not restored");
  a_mode_use: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_load |=> cur.rmode == $past(cur.sstw[31])) else $error("mode wrong");
  a_sync_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cur.st == ERS_SYNC && !sync_done_i) |=> cur.st == ERS_SYNC)
    else $error("return left sync early");
  a_trap_stall: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (trap_i && sb_upd != 32'h0) |=> trap_stall_o) else $error("trap not held");
  a_frz_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!shadow_on && !cr_wr_i && !exc_i) |=> $stable(cur.ssb))
    else $error("frozen shadow changed");
  a_ssb_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (shadow_on && !exc_i && !cr_wr_i) |=> cur.ssb == {$past(sb_upd[31:1]), 1'b0})
    else $error("shadow scoreboard lagging");
  a_exc_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (exc_i && cur.st == ERS_IDLE) |=> cur.sb == 32'h0) else $error("sb kept");
endmodule
`default_nettype wire

// File: logic/ers_shadow_ptr.sv
// Purpose: One shadow pointer that tracks a live stage pointer.
// Assumes: Tracking only while shadowing is enabled.
// Notes:   Software write always has priority over tracking.
`timescale 1ns/10ps
`default_nettype none
module ers_shadow_ptr
  import ers_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        track_i,   // Live pointer update, shadow enabled.
  input  wire logic [31:0] live_i,    // Live stage pointer word.
  input  wire logic        wr_i,      // Software write strobe.
  input  wire logic [31:0] wdata_i,   // Software write data.
  output var  logic [31:0] value_o    // Shadow pointer word.
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ptr; // Held pointer word.
  } ers_sp_t;
  ers_sp_t cur;  // Registered state.
  ers_sp_t next_cur; // Next state.

  // Software write wins; else follow the live pointer while tracking.
  always_comb begin
    next_cur = cur;
    if (wr_i) begin
      next_cur.ptr = wdata_i;
    end else if (track_i) begin
      next_cur.ptr = live_i;
    end
  end

  // Registers the state.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '{ptr: ERS_RST_WORD};
    end else begin
      cur <= next_cur;
    end
  end

  assign value_o = cur.ptr;
endmodule
`default_nettype wire

// File: pkg/ers_pkg.sv
// Purpose: Constants and types for the exception return shadow control.
// Assumes: 32-bit pointers and scoreboard, single processor clock.
// Notes:   Pointer words carry address in 31..2, valid in 1, fault in 0.
`default_nettype none
package ers_pkg;
  // ---------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------
  localparam int unsigned ERS_W         = 32;  // Register width.
  localparam int unsigned ERS_PTR_VALID = 1;   // Valid flag position.
  localparam int unsigned ERS_PTR_FAULT = 0;   // Fault flag position.
  localparam int unsigned ERS_ST_FRZ    = 0;   // Status freeze bit.
  localparam int unsigned ERS_ST_IND    = 1;   // Status interrupt disable.
  localparam int unsigned ERS_ST_MODE   = 31;  // Status privilege mode bit.
  // ---------------------------------------------------------------
  // Control register selectors and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] ERS_SEL_SSB  = 2'h0;  // Shadow scoreboard.
  localparam logic [1:0] ERS_SEL_SNP  = 2'h1;  // Shadow next pointer.
  localparam logic [1:0] ERS_SEL_SXP  = 2'h2;  // Shadow exec pointer.
  localparam logic [1:0] ERS_SEL_SFP  = 2'h3;  // Shadow fetch pointer.
  localparam logic [31:0] ERS_RST_WORD = 32'h0000_0000; // Reset value.
  localparam logic [31:0] ERS_RST_ST   = 32'h8000_000B; // Status at reset.
  // Return sequencer states.
  typedef enum logic [2:0] {
    ERS_IDLE,
    ERS_SYNC,
    ERS_LOAD,
    ERS_FETCH,
    ERS_DONE
  } ers_state_t;
endpackage
`default_nettype wire

// File: testbench/ers_pipe_model.sv
// Purpose: Pipeline and memory stand-in for the return sequencer.
// Assumes: Synchronisation and fetch replies arrive after fixed delays.
// Notes:   slow_i stretches both delays to exercise the waiting states.
`timescale 1ns/10ps
`default_nettype none
module ers_pipe_model (
  input  wire logic sys_clk_i,   // Processor clock.
  input  wire logic rst_i,       // Asynchronous reset, active high.
  input  wire logic ret_busy_i,  // Return sequence running.
  input  wire logic refetch_i,   // Prefetch request pulse.
  input  wire logic slow_i,      // Use long delays.
  output var  logic sync_done_o, // Earlier handler work complete.
  output var  logic fetch_ack_o  // Prefetched word arrived.
);
  logic [3:0] sync_cnt;  // Cycles spent inside the return.
  logic [3:0] ack_cnt;   // Cycles left before the fetch reply.
  // ---------------------------------------------------------------
  // Handler drain and memory reply
  // ---------------------------------------------------------------
  // Earlier work keeps draining for a while after the return issues.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_cnt    <= 4'h0;
      ack_cnt     <= 4'h0;
      fetch_ack_o <= 1'b0;
    end else begin
      sync_cnt    <= ret_busy_i ? sync_cnt + ((sync_cnt != 4'hF) ? 4'h1 : 4'h0) : 4'h0;
      ack_cnt     <= refetch_i ? (slow_i ? 4'h5 : 4'h1) : (ack_cnt != 4'h0) ? ack_cnt - 4'h1 : 4'h0;
      fetch_ack_o <= (ack_cnt == 4'h1);
    end
  end
  // Work completes only after the drain delay has run out.
  assign sync_done_o = ret_busy_i && (sync_cnt >= (slow_i ? 4'h6 : 4'h1));
endmodule
`default_nettype wire

// File: testbench/exception_return_shadow_ctrl_tb_top.sv
// Purpose: Self-checking bench for the exception return shadow control.
// Assumes: Registers are read two edges after the selector changes.
// Notes:   Pulses on the outputs are counted at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module exception_return_shadow_ctrl_tb_top;
  import ers_pkg::*;
  logic sys_clk_i, rst_i, sb_set_i, sb_clr_i, exc_i, fetch_adv_i, next_adv_i;
  logic taken_nodly_i, ret_i, sync_done, fetch_ack, trap_i, irq_pend_i, slow;
  logic cr_wr_i, cr_st_wr_i, cr_sst_wr_i, trap_stall_o, ret_busy_o, refetch_o;
  logic refetch_mode_o, ret_nop_o, iaccess_exc_o, irq_take_o, first_mode;
  logic       seen_nop;      // Resumed instruction marked as no-op.
  logic [4:0] sb_set_idx_i, sb_clr_idx_i;
  logic [1:0] cr_sel_i;
  logic [31:0] fetch_ptr_i, next_ptr_i, cr_wdata_i, cr_rdata_o, live_sb_o;
  logic [31:0] status_o, saved_status_o, refetch_addr_o, exec_ptr_o, first_addr;
  int n_errors, checks_done, n_fetch, n_iexc, n_irq, cyc;
  // ---------------------------------------------------------------
  // Design, far side and clock
  // ---------------------------------------------------------------
  ers_ctrl i_ers_ctrl (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sb_set_i(sb_set_i),
    .sb_set_idx_i(sb_set_idx_i), .sb_clr_i(sb_clr_i), .sb_clr_idx_i(sb_clr_idx_i),
    .exc_i(exc_i), .fetch_adv_i(fetch_adv_i), .fetch_ptr_i(fetch_ptr_i),
    .next_adv_i(next_adv_i), .next_ptr_i(next_ptr_i), .taken_nodly_i(taken_nodly_i),
    .ret_i(ret_i), .sync_done_i(sync_done), .fetch_ack_i(fetch_ack),
    .trap_i(trap_i), .irq_pend_i(irq_pend_i), .cr_wr_i(cr_wr_i),
    .cr_st_wr_i(cr_st_wr_i), .cr_sst_wr_i(cr_sst_wr_i), .cr_sel_i(cr_sel_i),
    .cr_wdata_i(cr_wdata_i), .cr_rdata_o(cr_rdata_o), .live_sb_o(live_sb_o),
    .status_o(status_o), .saved_status_o(saved_status_o),
    .trap_stall_o(trap_stall_o), .ret_busy_o(ret_busy_o), .refetch_o(refetch_o),
    .refetch_addr_o(refetch_addr_o), .refetch_mode_o(refetch_mode_o),
    .ret_nop_o(ret_nop_o), .iaccess_exc_o(iaccess_exc_o),
    .irq_take_o(irq_take_o), .exec_ptr_o(exec_ptr_o));
  ers_pipe_model i_ers_pipe_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .ret_busy_i(ret_busy_o), .refetch_i(refetch_o), .slow_i(slow),
    .sync_done_o(sync_done), .fetch_ack_o(fetch_ack));
  // A 40 ns period gives the 25 MHz processor clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // Pulses are counted away from the rising edge to avoid races.
  always @(negedge sys_clk_i) begin
    if (refetch_o === 1'b1 && n_fetch == 0) begin
      first_addr = refetch_addr_o;
      first_mode = refetch_mode_o;
    end
    if (refetch_o === 1'b1) n_fetch++;
    if (iaccess_exc_o === 1'b1) n_iexc++;
    if (irq_take_o === 1'b1) n_irq++;
    if (ret_nop_o === 1'b1) seen_nop = 1'b1;
  end
  // A hang is cut short well after the tests should have finished.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Reads a shadow register and compares it.
  task automatic chk_reg(input logic [1:0] sel, input logic [31:0] exp);
    @(posedge sys_clk_i);
    cr_sel_i <= sel;
    repeat (2) @(posedge sys_clk_i);
    #1 check(cr_rdata_o, exp);
  endtask
  // Software write: k 0 control register, 1 status, 2 saved status.
  task automatic wr(input int k, input logic [1:0] sel, input logic [31:0] d);
    @(posedge sys_clk_i);
    cr_sel_i    <= sel;
    cr_wdata_i  <= d;
    cr_wr_i     <= (k == 0);
    cr_st_wr_i  <= (k == 1);
    cr_sst_wr_i <= (k == 2);
    @(posedge sys_clk_i);
    {cr_wr_i, cr_st_wr_i, cr_sst_wr_i} <= 3'h0;
    #1;
  endtask
  // Scoreboard strobe: set when s is high, otherwise release.
  task automatic sb(input logic s, input logic [4:0] idx);
    @(posedge sys_clk_i);
    {sb_set_i, sb_set_idx_i, sb_clr_i, sb_clr_idx_i} <= {s, idx, ~s, idx};
    @(posedge sys_clk_i);
    {sb_set_i, sb_clr_i} <= 2'h0;
    #1;
  endtask
  // Stage advance: f selects fetch, otherwise next stage.
  task automatic adv(input logic f, input logic nd, input logic [31:0] p);
    @(posedge sys_clk_i);
    {fetch_adv_i, next_adv_i, taken_nodly_i} <= {f, ~f, nd};
    fetch_ptr_i <= p;
    next_ptr_i  <= p;
    @(posedge sys_clk_i);
    {fetch_adv_i, next_adv_i, taken_nodly_i} <= 3'h0;
    #1;
  endtask
  // Runs one return with chosen shadow next, fetch and saved status.
  task automatic run_ret(input logic [31:0] snp, input logic [31:0] sfp,
                         input logic [31:0] sst, input logic s);
    int i;
    wr(0, ERS_SEL_SNP, snp);
    wr(0, ERS_SEL_SFP, sfp);
    wr(2, 2'h0, sst);
    {n_fetch, n_iexc, n_irq, seen_nop, slow} = {96'h0, 1'b0, s};
    @(posedge sys_clk_i);
    ret_i <= 1'b1;
    @(posedge sys_clk_i);
    ret_i <= 1'b0;
    #1 check(ret_busy_o, 32'h1);
    repeat (3) @(posedge sys_clk_i);
    #1 check(n_fetch, 32'h0);
    for (i = 0; i < 100 && ret_busy_o !== 1'b0; i++) @(negedge sys_clk_i);
    repeat (2) @(posedge sys_clk_i);
    #1 check(first_addr & 32'hFFFF_FFFC, (snp[1] ? snp : sfp) & 32'hFFFF_FFFC);
    check(first_mode, sst[ERS_ST_MODE]);
    check(status_o, sst);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    check(status_o, 32'h8000_000B);
    wr(0, ERS_SEL_SSB, 32'h0000_0000);
    wr(0, ERS_SEL_SSB, 32'hFFFF_FFFF);
    chk_reg(ERS_SEL_SSB, 32'hFFFF_FFFE);
    wr(0, ERS_SEL_SNP, 32'h1234_5677);
    chk_reg(ERS_SEL_SNP, 32'h1234_5677);
    wr(0, ERS_SEL_SXP, 32'hFFFF_FFFF);
    chk_reg(ERS_SEL_SXP, 32'h0000_0000);
    sb(1'b1, 5'h05);
    adv(1'b1, 1'b0, 32'h0000_0F03);
    check(live_sb_o, 32'h0000_0020);
    chk_reg(ERS_SEL_SSB, 32'hFFFF_FFFE);
    chk_reg(ERS_SEL_SNP, 32'h1234_5677);
    sb(1'b0, 5'h05);
    $display("registers and freeze test done");
  endtask
  task automatic t_track();
    wr(0, ERS_SEL_SSB, 32'h0000_0000);
    wr(1, 2'h0, 32'h8000_000A);
    sb(1'b1, 5'h07);
    chk_reg(ERS_SEL_SSB, 32'h0000_0080);
    @(posedge sys_clk_i);
    trap_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 check(trap_stall_o, 32'h1);
    sb(1'b0, 5'h07);
    repeat (2) @(posedge sys_clk_i);
    trap_i <= 1'b0;
    #1 check(trap_stall_o, 32'h0);
    adv(1'b1, 1'b0, 32'h0000_1003);
    chk_reg(ERS_SEL_SNP, 32'h0000_1003);
    adv(1'b1, 1'b0, 32'h0000_2001);
    chk_reg(ERS_SEL_SNP, 32'h0000_2001);
    adv(1'b1, 1'b1, 32'h0000_3002);
    chk_reg(ERS_SEL_SNP, 32'h0000_3000);
    adv(1'b0, 1'b0, 32'h0000_4002);
    chk_reg(ERS_SEL_SXP, 32'h0000_4002);
    adv(1'b0, 1'b0, 32'h0000_5001);
    chk_reg(ERS_SEL_SXP, 32'h0000_5001);
    adv(1'b0, 1'b0, 32'h0000_6003);
    check(exec_ptr_o, 32'h0000_6003);
    sb(1'b1, 5'h09);
    @(posedge sys_clk_i);
    exc_i <= 1'b1;
    @(posedge sys_clk_i);
    exc_i <= 1'b0;
    #1 check(live_sb_o, 32'h0000_0000);
    check(saved_status_o, 32'h8000_000A);
    check(status_o, 32'h8000_000B);
    chk_reg(ERS_SEL_SSB, 32'h0000_0200);
    $display("tracking test done");
  endtask
  task automatic t_ret();
    wr(1, 2'h0, 32'h8000_000B);
    wr(0, ERS_SEL_SSB, 32'h0000_0300);
    irq_pend_i <= 1'b1;
    run_ret(32'h0008_4002, 32'h0008_4006, 32'h0000_0000, 1'b1);
    check(live_sb_o, 32'h0000_0300);
    check(n_irq, 32'h1);
    check({n_iexc[0], seen_nop}, 32'h0);
    wr(1, 2'h0, 32'h8000_000B);
    run_ret(32'h0000_9003, 32'h0000_9006, 32'h8000_0003, 1'b0);
    check(n_iexc, 32'h1);
    check(n_irq, 32'h0);
    irq_pend_i <= 1'b0;
    run_ret(32'h0000_A001, 32'h0000_B002, 32'h8000_0003, 1'b0);
    check({n_iexc[0], seen_nop}, 32'h1);
    $display("return test done");
  endtask
  initial begin
    {rst_i, sb_set_i, sb_clr_i, exc_i, fetch_adv_i, next_adv_i} = 6'h20;
    {taken_nodly_i, ret_i, trap_i, irq_pend_i, slow} = 5'h0;
    {cr_wr_i, cr_st_wr_i, cr_sst_wr_i, cr_sel_i} = 5'h0;
    {sb_set_idx_i, sb_clr_idx_i, fetch_ptr_i, next_ptr_i, cr_wdata_i} = 106'h0;
    {n_errors, checks_done, n_fetch, n_iexc, n_irq, cyc} = 192'h0;
    {seen_nop, first_mode, first_addr} = 34'h0;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 t_regs();
    t_track();
    t_ret();
    final_report();
  end
endmodule
`default_nettype wire
